// [inc/upft_cfg.svh]
// constants for the upstream port failover trigger
`ifndef UPFT_CFG_SVH
`define UPFT_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UPFT_OFS_CTRL 8'h00
`define UPFT_OFS_STAT 8'h04
`define UPFT_OFS_WDOG 8'h08
// ----------------------------------------
// control fields
// ----------------------------------------
`define UPFT_CTL_MSEL 0
`define UPFT_CTL_SIGNAL_FAILOVER_ENABLE 1
`define UPFT_CTL_TIMER_FAILOVER_ENABLE 2
`define UPFT_CTL_ILDDIS 3
`define UPFT_CTL_ELDDIS 4
`define UPFT_CTL_FRDIS 5
`define UPFT_CTL_IHPDIS 6
`define UPFT_CTL_EHPDIS 7
// ----------------------------------------
// status fields
// ----------------------------------------
`define UPFT_STS_MODE 0
`define UPFT_STS_INIT 1
`define UPFT_STS_DONE 2
`define UPFT_STS_BUSY 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define UPFT_CTRL_RST 8'h00
`define UPFT_WDOG_RST 32'h0000_0000
`define UPFT_CLK_MHZ 100
`define UPFT_TICK_US 1
`define UPFT_TICK_CYC (`UPFT_CLK_MHZ * `UPFT_TICK_US)
`endif

// [inc/upft_pkg.sv]
// types for the upstream port failover trigger
package upft_pkg;
	typedef enum logic [1:0] {
		UPFT_SRC_SW,
		UPFT_SRC_SIG,
		UPFT_SRC_WDT
	} upft_src_t;
	typedef enum logic [1:0] {
		UPFT_IDLE,
		UPFT_DOWN,
		UPFT_SWAP,
		UPFT_TRAIN
	} upft_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} upft_bus_t;
	typedef struct packed {
		logic a_linkdown;
		logic c_linkdown;
		logic a_hotrst_ts;
		logic c_hotrst_ts;
	} upft_evt_t;
endpackage

// [hdl/upft_top.sv]
// upstream port failover trigger: request arbitration, swap sequence, reset gating
`timescale 1ns/1ns
`default_nettype none
`include "upft_cfg.svh"
module upft_top import upft_pkg::*; #(
	parameter int WDOG_W = 32,
	parameter int DOWN_CYC = 4,
	parameter int SWAP_CYC = 4
) (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	input wire upft_pkg::upft_bus_t BUS_I,
	output logic [31:0] RDATA_O,
	input wire logic GPIO5_I,
	input wire logic HOT_RESET_I,
	input wire upft_pkg::upft_evt_t EVT_I,
	input wire logic TRAIN_DONE_I,
	output logic PORTS_DETECT_O,
	output logic LANES_SWAPPED_O,
	output logic PORTS_TRAIN_O,
	output logic INT_DOMAIN_RST_O,
	output logic EXT_DOMAIN_RST_O
);
	import upft_pkg::*;

	// ----------------------------------------
	// parameter limits
	// ----------------------------------------
	// step counter is eight bits and the watchdog read path is 32 bits
	initial begin
		if (WDOG_W < 32) begin
			$error("upft_top: WDOG_W below 32 is not supported");
		end
		if (DOWN_CYC < 1 || DOWN_CYC > 255) begin
			$error("upft_top: DOWN_CYC out of range");
		end
		if (SWAP_CYC < 1 || SWAP_CYC > 255) begin
			$error("upft_top: SWAP_CYC out of range");
		end
	end

	// ----------------------------------------
	// register bus decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// unmapped offsets read as zero and ignore writes
	wire sel_ctrl = hit(BUS_I.addr, `UPFT_OFS_CTRL);
	wire sel_stat = hit(BUS_I.addr, `UPFT_OFS_STAT);
	wire sel_wdog = hit(BUS_I.addr, `UPFT_OFS_WDOG);
	wire wr_ctrl = BUS_I.wr && sel_ctrl;
	wire wr_stat = BUS_I.wr && sel_stat;
	wire wr_wdog = BUS_I.wr && sel_wdog;

	// status word layout
	function automatic logic [31:0] status_word(input logic m, input logic i, input logic d,
		input logic b);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UPFT_STS_MODE] = m;
		w[`UPFT_STS_INIT] = i;
		w[`UPFT_STS_DONE] = d;
		w[`UPFT_STS_BUSY] = b;
		return w;
	endfunction

	logic [7:0] ctrl_q;
	logic [WDOG_W-1:0] wdog_q;
	logic mode_q;
	logic init_q;
	logic done_q;
	logic pin_q;
	logic [6:0] tick_q;
	upft_state_t st_q;
	logic [7:0] step_q;
	logic tgt_q;
	upft_src_t src_q;
	logic [2:0] pend_q;
	logic pend_sw_tgt_q;
	logic fo_window_q;

	wire busy = st_q != UPFT_IDLE;

	// ----------------------------------------
	// control field taps
	// ----------------------------------------
	// disable bits act at once; software orders its own writes
	wire cfg_msel = ctrl_q[`UPFT_CTL_MSEL];
	wire cfg_sig_en = ctrl_q[`UPFT_CTL_SIGNAL_FAILOVER_ENABLE];
	wire cfg_tim_en = ctrl_q[`UPFT_CTL_TIMER_FAILOVER_ENABLE];
	wire ld_dis_int = ctrl_q[`UPFT_CTL_ILDDIS];
	wire ld_dis_ext = ctrl_q[`UPFT_CTL_ELDDIS];
	wire fo_rst_dis = ctrl_q[`UPFT_CTL_FRDIS];
	wire hp_dis_int = ctrl_q[`UPFT_CTL_IHPDIS];
	wire hp_dis_ext = ctrl_q[`UPFT_CTL_EHPDIS];

	// ----------------------------------------
	// request sources
	// ----------------------------------------
	wire msel_new = BUS_I.wdata[`UPFT_CTL_MSEL];
	wire req_sw = wr_ctrl && (msel_new != cfg_msel);
	// pin taken straight from the pad regardless of pin function
	// limitation: a pin that moves again mid-swap is seen only afterwards
	wire req_sig = cfg_sig_en && (pin_q != mode_q);
	// prescaler runs free, so the first tick after a load may come early
	wire tick = tick_q == 7'(`UPFT_TICK_CYC - 1);
	wire wdog_dec = tick && (wdog_q != '0) && !wr_wdog;
	wire req_wdt = cfg_tim_en && wdog_dec && (wdog_q == WDOG_W'(1));

	// ----------------------------------------
	// request arbitration
	// ----------------------------------------
	// level-style signal request stays asserted until the mode matches
	wire [2:0] req_vec = {req_wdt, req_sig, req_sw};
	// pending of the running type is dropped, others kept
	wire [2:0] run_mask = busy ? (3'b001 << src_q) : 3'b000;
	wire [2:0] pend_d_raw = (pend_q | req_vec) & ~run_mask;
	wire start = !busy && (pend_q != 3'b000);
	wire [1:0] pick = pend_q[0] ? 2'd0 : (pend_q[1] ? 2'd1 : 2'd2);
	// watchdog flips the reported mode; signal follows the pin
	wire pick_tgt = pick == 2'd0 ? pend_sw_tgt_q : (pick == 2'd1 ? pin_q : !mode_q);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_q <= `UPFT_CTRL_RST;
			pin_q <= 1'b0;
			pend_sw_tgt_q <= 1'b0;
		end else begin
			pin_q <= GPIO5_I;
			if (wr_ctrl) begin
				ctrl_q <= BUS_I.wdata[7:0];
			end
			if (req_sw) begin
				pend_sw_tgt_q <= msel_new;
			end
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// watchdog sees only the fundamental reset
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wdog_q <= WDOG_W'(`UPFT_WDOG_RST);
			tick_q <= '0;
		end else begin
			tick_q <= tick ? 7'd0 : tick_q + 7'd1;
			if (wr_wdog) begin
				wdog_q <= WDOG_W'(BUS_I.wdata);
			end else if (wdog_dec) begin
				wdog_q <= wdog_q - WDOG_W'(1);
			end
		end
	end

	// ----------------------------------------
	// failover sequence
	// ----------------------------------------
	wire seq_done = st_q == UPFT_TRAIN && TRAIN_DONE_I;
	// done flag rides the same edge as the return to idle
	wire down_last = step_q == 8'(DOWN_CYC - 1);
	wire swap_last = step_q == 8'(SWAP_CYC - 1);
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			st_q <= UPFT_IDLE;
			step_q <= '0;
			tgt_q <= 1'b0;
			src_q <= UPFT_SRC_SW;
			pend_q <= '0;
			mode_q <= 1'b0;
		end else begin
			// hot reset does not touch the sequence
			pend_q <= start ? (pend_d_raw & ~(3'b001 << pick)) : pend_d_raw;
			case (st_q)
				UPFT_IDLE: begin
					if (start) begin
						st_q <= UPFT_DOWN;
						tgt_q <= pick_tgt;
						src_q <= upft_src_t'(pick);
						step_q <= '0;
					end
				end
				UPFT_DOWN: begin
					step_q <= step_q + 8'd1;
					if (down_last) begin
						st_q <= UPFT_SWAP;
						step_q <= '0;
						mode_q <= tgt_q;
					end
				end
				UPFT_SWAP: begin
					step_q <= step_q + 8'd1;
					if (swap_last) begin
						st_q <= UPFT_TRAIN;
					end
				end
				UPFT_TRAIN: begin
					if (TRAIN_DONE_I) begin
						st_q <= UPFT_IDLE;
					end
				end
				default: begin
					st_q <= UPFT_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// sticky flags, set beats a software clear
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			init_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			init_q <= start || (init_q && !(wr_stat && BUS_I.wdata[`UPFT_STS_INIT]));
			done_q <= seq_done || (done_q && !(wr_stat && BUS_I.wdata[`UPFT_STS_DONE]));
		end
	end

	// ----------------------------------------
	// domain reset gating
	// ----------------------------------------
	// link-downs during a swap are blamed on the failover, not the link
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			fo_window_q <= 1'b0;
		end else begin
			fo_window_q <= busy || start;
		end
	end

	wire fo_mask = fo_window_q && fo_rst_dis;
	wire a_ld = EVT_I.a_linkdown && !ld_dis_int && !fo_mask;
	wire c_ld = EVT_I.c_linkdown && !ld_dis_ext && !fo_mask;
	wire a_hr = EVT_I.a_hotrst_ts && !hp_dis_int;
	wire c_hr = EVT_I.c_hotrst_ts && !hp_dis_ext;
	// port A feeds both domains, since the external side hangs below it
	wire int_rst_d = a_ld || a_hr;
	wire ext_rst_d = a_ld || a_hr || c_ld || c_hr;

	// ----------------------------------------
	// read path and outputs
	// ----------------------------------------
	wire [31:0] rd_mux =
		sel_ctrl ? {24'h00_0000, ctrl_q} :
		sel_stat ? status_word(mode_q, init_q, done_q, busy) :
		sel_wdog ? wdog_q[31:0] : 32'h0000_0000;
	// port state outputs are one flop behind the sequencer
	wire detect_d = st_q == UPFT_DOWN;
	wire train_d = st_q == UPFT_TRAIN;
	// an outside hot reset is passed on whatever the disable bits say

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RDATA_O <= 32'h0000_0000;
			PORTS_DETECT_O <= 1'b0;
			LANES_SWAPPED_O <= 1'b0;
			PORTS_TRAIN_O <= 1'b0;
			INT_DOMAIN_RST_O <= 1'b0;
			EXT_DOMAIN_RST_O <= 1'b0;
		end else begin
			RDATA_O <= BUS_I.rd ? rd_mux : 32'h0000_0000;
			PORTS_DETECT_O <= detect_d;
			LANES_SWAPPED_O <= mode_q;
			PORTS_TRAIN_O <= train_d;
			INT_DOMAIN_RST_O <= int_rst_d || HOT_RESET_I;
			EXT_DOMAIN_RST_O <= ext_rst_d || HOT_RESET_I;
		end
	end
endmodule
`default_nettype wire

// [dv/upft_properties.sv]
// port checker for the failover trigger
`timescale 1ns/1ns
`default_nettype none
module upft_properties (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	input wire upft_pkg::upft_bus_t BUS_I,
	input wire upft_pkg::upft_evt_t EVT_I,
	input wire logic HOT_RESET_I,
	input wire logic TRAIN_DONE_I,
	input wire logic PORTS_DETECT_O,
	input wire logic LANES_SWAPPED_O,
	input wire logic PORTS_TRAIN_O,
	input wire logic INT_DOMAIN_RST_O,
	input wire logic EXT_DOMAIN_RST_O
);
	import upft_pkg::*;
	logic [7:0] ctl_q;
	wire ir = INT_DOMAIN_RST_O;
	wire er = EXT_DOMAIN_RST_O;
	wire det = PORTS_DETECT_O;
	wire trn = PORTS_TRAIN_O;
	// shadow of the control word, the disable bits are not visible at the ports
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			ctl_q <= 8'h00;
		else if (BUS_I.wr && BUS_I.addr == 8'h00)
			ctl_q <= BUS_I.wdata[7:0];
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	a_hot_both: assert property (HOT_RESET_I |=> ir && er)
		else $error("hot reset not passed on");
	a_int_ld_mask: assert property (EVT_I == 4'h8 && !HOT_RESET_I && ctl_q[3] |=> !ir && !er)
		else $error("port A link-down not masked");
	a_ext_ld_mask: assert property (EVT_I == 4'h4 && !HOT_RESET_I && ctl_q[4] |=> !er)
		else $error("port C link-down not masked");
	a_int_ts_mask: assert property (EVT_I == 4'h2 && !HOT_RESET_I && ctl_q[6] |=> !ir && !er)
		else $error("upstream hot-reset sets not ignored");
	a_ext_ts_mask: assert property (EVT_I == 4'h1 && !HOT_RESET_I && ctl_q[7] |=> !er)
		else $error("bridge hot-reset sets not ignored");
	a_lane_in_down: assert property ($changed(LANES_SWAPPED_O) |-> $past(det) || $past(det, 2))
		else $error("lanes moved outside detect");
	a_train_on_done: assert property ($fell(trn) |-> $past(TRAIN_DONE_I) || $past(TRAIN_DONE_I, 2))
		else $error("training ended without done");
	a_detect_hold: assert property ($rose(det) |-> det[*4])
		else $error("detect phase cut short");
	a_no_overlap: assert property (!(det && trn))
		else $error("detect and training together");
	cover property ($rose(det));
	cover property ($fell(trn));
	cover property (EVT_I != 4'h0 && ctl_q[7:3] != 5'h00);
endmodule
bind upft_top upft_properties u_props (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
	.BUS_I(BUS_I), .EVT_I(EVT_I), .HOT_RESET_I(HOT_RESET_I), .TRAIN_DONE_I(TRAIN_DONE_I),
	.PORTS_DETECT_O(PORTS_DETECT_O), .LANES_SWAPPED_O(LANES_SWAPPED_O),
	.PORTS_TRAIN_O(PORTS_TRAIN_O), .INT_DOMAIN_RST_O(INT_DOMAIN_RST_O),
	.EXT_DOMAIN_RST_O(EXT_DOMAIN_RST_O));
`default_nettype wire

// [dv/upft_gpio_model.sv]
// external monitor driving the failover input pin
`timescale 1ns/1ns
`default_nettype none
module upft_gpio_model #(
	parameter int MIN_GAP = 50
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic want_i,
	output logic pin_o
);
	int gap_q;
	// spacing shortened from one second so the run stays short
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_q <= 0;
			pin_o <= 1'b0;
		end else if (want_i != pin_o && gap_q >= MIN_GAP) begin
			gap_q <= 0;
			pin_o <= want_i;
		end else if (gap_q < MIN_GAP)
			gap_q <= gap_q + 1;
	end
endmodule
`default_nettype wire

// [dv/upft_top_tb_top.sv]
// self-checking bench for the failover trigger
`timescale 1ns/1ns
`default_nettype none
module upft_top_tb_top;
	import upft_pkg::*;
	logic clk = 0, rst_n = 0, hot = 0, done = 0, want = 0, pin;
	logic det, lan, trn, ir, er;
	logic [31:0] rdat, d, n, seed = 32'hadc8_cf91;
	upft_bus_t bus = '0;
	upft_evt_t evt = '0;
	int err_count = 0, samples_checked = 0, cyc = 0, j;
	upft_top i_dut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .BUS_I(bus), .RDATA_O(rdat),
		.GPIO5_I(pin), .HOT_RESET_I(hot), .EVT_I(evt), .TRAIN_DONE_I(done),
		.PORTS_DETECT_O(det), .LANES_SWAPPED_O(lan), .PORTS_TRAIN_O(trn),
		.INT_DOMAIN_RST_O(ir), .EXT_DOMAIN_RST_O(er));
	upft_gpio_model i_mon (.clk_i(clk), .rst_n_i(rst_n), .want_i(want), .pin_o(pin));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 d = rdat;
	endtask
	// waits out a running swap, then checks mode, flags and busy
	task settle(input logic [3:0] e);
		repeat (3) @(posedge clk);
		d = 32'h0000_0008;
		for (int k = 0; k < 300 && d[3]; k++) rd(8'h04);
		chk(d[3:0], e);
	endtask
	task ev(input upft_evt_t v, input logic ei, input logic ee);
		@(posedge clk) evt <= v;
		@(posedge clk) evt <= '0;
		#1 chk({ir, er}, {ei, ee});
	endtask
	initial forever #5 clk = ~clk;
	// random retrain completion and the run ceiling
	always @(posedge clk) begin
		done <= ^xs();
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wr(8'h0c, 32'hffff_ffff);
		for (int a = 0; a < 16; a += 4) begin
			rd(a[7:0]);
			chk(d, 32'h0000_0000);
		end
		wr(8'h00, 32'h0000_0021);
		for (int k = 0; k < 20 && !det; k++) @(negedge clk);
		ev(4'h8, 1'b0, 1'b0);
		settle(4'h7);
		chk({31'h0000_0000, lan}, 32'h0000_0001);
		wr(8'h04, 32'h0000_0006);
		rd(8'h04);
		chk(d, 32'h0000_0001);
		want <= 1'b1;
		n = 32'd2 + xs() % 32'd4;
		wr(8'h00, 32'h0000_0025);
		wr(8'h08, n);
		@(posedge clk) hot <= 1'b1;
		@(posedge clk) hot <= 1'b0;
		#1 chk({ir, er}, 2'h3);
		repeat (n * 100 - 110) @(posedge clk);
		rd(8'h08);
		chk(d != 0, 1'b1);
		repeat (130) @(posedge clk);
		rd(8'h08);
		chk(d, 32'h0000_0000);
		settle(4'h6);
		chk({31'h0000_0000, lan}, 32'h0000_0000);
		wr(8'h00, 32'h0000_0023);
		settle(4'h7);
		for (int i = 0; i < 8; i++) begin
			j = i / 2;
			wr(8'h00, 32'h1 | ((i % 2) << (j < 2 ? 3 + j : 4 + j)));
			ev(upft_evt_t'(4'h8 >> j), !i[0] && !j[0], !i[0]);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
